//--- pkg/pic_map.vh
/*
 Constants for the probe input conditioning block: value widths, limits,
 setting codes and defaults.
 Assumes the includer wants plain `define names with no other content.
*/
// Function
// - Linear band spans 9999 internal units
// - Factory end points fixed, never written
// - Linear map between two configured points
// - Four scaling settings, config level only
// - Integer or decimal point display variant
// - Second probe off by default, same type
// - Second probe feeds program and holdback
// - Shared setpoint, independent loop outputs
// - Cold junction setting only for thermocouples
// - Cold junction internal or 0/25/40/50
// - Offset added, used for display and control
// - Offset range -999 to 9999, default 0
// - Filter factor from fixed set, default 4
// - Larger factor smooths more, responds slower
// - Linear reading outside break limits faults
// - Fault message and probe flag shown
// - Failed probe switches its output off
// - Fault during run forces holdback
// - Fault persists until the next good sample
// - Idle fault only messages, blocks run
// - Fault clears automatically when input good
`ifndef PIC_MAP_VH
`define PIC_MAP_VH
`define PIC_W 16
`define PIC_INT_SPAN 16'sd9999
`define PIC_INT_MIN 16'sd0
`define PIC_OFS_MIN -16'sd999
`define PIC_OFS_MAX 16'sd9999
`define PIC_OFS_DEF 16'sd0
`define PIC_DISP_MIN -16'sd1999
`define PIC_DISP_MAX 16'sd9999
`define PIC_SENS_TC 2'h0
`define PIC_SENS_RTD 2'h1
`define PIC_SENS_LIN 2'h2
`define PIC_SENS_LIN_DP 2'h3
`define PIC_CJ_INT 3'h0
`define PIC_CJ_0 3'h1
`define PIC_CJ_25 3'h2
`define PIC_CJ_40 3'h3
`define PIC_CJ_50 3'h4
`define PIC_CJV_0 16'sd0
`define PIC_CJV_25 16'sd25
`define PIC_CJV_40 16'sd40
`define PIC_CJV_50 16'sd50
`define PIC_FLT_DEF 3'h2
`define PIC_FLT_1 8'h01
`define PIC_FLT_2 8'h02
`define PIC_FLT_4 8'h04
`define PIC_FLT_9 8'h09
`define PIC_FLT_15 8'h0f
`define PIC_FLT_32 8'h20
`define PIC_FLT_54 8'h36
`define PIC_FLT_129 8'h81
`define PIC_ST_IDLE 2'h0
`define PIC_ST_RUN 2'h1
`define PIC_ST_HOLD 2'h2
`define PIC_ST_END 2'h3
`endif

//--- rtl/pic_top.v
/*
 Probe input conditioning: linear scaling, cold junction correction,
 offset, recursive filter, sensor break detection and faulty-probe mode
 for two probes sharing one program state.
 Assumes raw readings arrive with a one-cycle valid strobe each, already
 in internal units (linear) or degrees (thermocouple, RTD), synchronous
 to i_clk. Settings are held stable by the configuration logic.
*/
`include "pic_map.vh"

module pic_ch
(
	input wire i_clk,
	input wire i_sys_rst,
	input wire i_ce,
	input wire i_valid,
	input wire signed [15:0] i_raw,
	input wire i_lin,
	input wire [1:0] i_sens,
	input wire signed [15:0] i_cj,
	input wire signed [15:0] i_in1,
	input wire signed [15:0] i_rd1,
	input wire signed [15:0] i_in2,
	input wire signed [15:0] i_rd2,
	input wire signed [15:0] i_ofs,
	input wire [7:0] i_fac,
	input wire signed [15:0] i_brk_hi,
	input wire signed [15:0] i_brk_lo,
	input wire i_hw_fault,
	output wire o_fault,
	output wire signed [15:0] o_value
);
	reg signed [31:0] acc_reg;
	reg signed [31:0] acc_next;
	reg prim_reg;
	reg fault_reg;
	reg signed [15:0] val_reg;
	reg signed [15:0] val_next;
	reg signed [31:0] scaled;
	reg signed [31:0] num;
	reg signed [31:0] den;
	reg signed [31:0] corr;
	reg signed [31:0] sum;
	reg signed [31:0] rin;
	reg brk;
	reg signed [31:0] fs;

	// ---------------------------------------------------------------
	// Scaling, compensation, break check
	// ---------------------------------------------------------------
	always @*
	begin
		rin = {{16{i_raw[15]}}, i_raw};
		// Clamp the raw linear reading into the factory band
		if (i_lin && rin > `PIC_INT_SPAN)
			rin = `PIC_INT_SPAN;
		if (i_lin && rin < `PIC_INT_MIN)
			rin = `PIC_INT_MIN;
		den = i_in2 - i_in1;
		num = (rin - i_in1) * (i_rd2 - i_rd1);
		if (den == 32'sd0)
			scaled = i_rd1;
		else
			scaled = i_rd1 + num / den;
		if (!i_lin)
			corr = (i_sens == `PIC_SENS_TC) ? rin + i_cj : rin;
		else
			corr = scaled;
		brk = i_lin && (corr > i_brk_hi || corr < i_brk_lo);
	end

	// ---------------------------------------------------------------
	// Recursive average filter and offset
	// ---------------------------------------------------------------
	always @*
	begin
		// Signed copy of the factor keeps negative averages exact
		fs = {24'h0, i_fac};
		// Stored value is factor times the average; a new sample adds 1/factor
		if (!prim_reg)
			acc_next = corr * fs;
		else
			acc_next = acc_reg + corr - acc_reg / fs;
		sum = acc_next / fs + i_ofs;
		if (sum > `PIC_DISP_MAX)
			val_next = `PIC_DISP_MAX;
		else if (sum < `PIC_DISP_MIN)
			val_next = `PIC_DISP_MIN;
		else
			val_next = sum[15:0];
	end

	always @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			acc_reg <= 32'sh0;
			prim_reg <= 1'b0;
			fault_reg <= 1'b0;
			val_reg <= 16'sh0;
		end
		else if (i_ce && i_valid)
		begin
			// Fault follows the input each sample, clearing by itself
			fault_reg <= brk || i_hw_fault;
			if (!(brk || i_hw_fault))
			begin
				acc_reg <= acc_next;
				prim_reg <= 1'b1;
				val_reg <= val_next;
			end
		end
	end

	assign o_fault = fault_reg;
	assign o_value = val_reg;
endmodule

module pic_top
(
	input wire i_clk,
	input wire i_sys_rst,
	input wire i_ce,
	input wire [1:0] i_sensor_type,
	input wire [2:0] i_cold_junction_mode,
	input wire signed [15:0] i_cold_junction_internal,
	input wire signed [15:0] i_scale_start_input,
	input wire signed [15:0] i_scale_start_display,
	input wire signed [15:0] i_scale_end_input,
	input wire signed [15:0] i_scale_end_display,
	input wire i_config_level,
	input wire i_cfg_write,
	input wire i_second_probe_enable,
	input wire signed [15:0] i_probe1_offset,
	input wire signed [15:0] i_probe2_offset,
	input wire [2:0] i_input_filter_factor,
	input wire signed [15:0] i_break_upper_limit,
	input wire signed [15:0] i_break_lower_limit,
	input wire i_p1_valid,
	input wire signed [15:0] i_p1_raw,
	input wire i_p1_hw_fault,
	input wire i_p2_valid,
	input wire signed [15:0] i_p2_raw,
	input wire i_p2_hw_fault,
	input wire i_run_req,
	input wire i_idle_req,
	input wire i_prog_end,
	input wire i_ctrl1_out,
	input wire i_ctrl2_out,
	output wire signed [15:0] o_probe1_value,
	output wire signed [15:0] o_probe2_value,
	output wire signed [15:0] o_prog_value,
	output wire o_decimal_point,
	output wire o_cj_visible,
	output wire o_sensor_fault_message,
	output wire o_probe1_fault_flag,
	output wire o_probe2_fault_flag,
	output wire o_holdback_message,
	output wire o_run_refused,
	output wire o_out1,
	output wire o_out2,
	output wire [1:0] o_prog_state
);
	reg signed [15:0] in1_reg;
	reg signed [15:0] rd1_reg;
	reg signed [15:0] in2_reg;
	reg signed [15:0] rd2_reg;
	reg sp2_reg;
	reg [2:0] cjm_reg;
	reg signed [15:0] ofs1_reg;
	reg signed [15:0] ofs2_reg;
	reg [2:0] flt_reg;
	reg [1:0] st_reg;
	reg [1:0] st_next;
	reg signed [15:0] cj;
	reg [7:0] fac;
	reg signed [15:0] prog_reg;
	wire lin;
	wire f1;
	wire f2;
	wire f2_raw;
	wire any_f;
	wire signed [15:0] v1;
	wire signed [15:0] v2;

	assign lin = i_sensor_type[1];

	// ---------------------------------------------------------------
	// Settings, defaults after reset
	// ---------------------------------------------------------------
	always @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			in1_reg <= `PIC_INT_MIN;
			rd1_reg <= `PIC_INT_MIN;
			in2_reg <= `PIC_INT_SPAN;
			rd2_reg <= `PIC_INT_SPAN;
			sp2_reg <= 1'b0;
			cjm_reg <= `PIC_CJ_INT;
			ofs1_reg <= `PIC_OFS_DEF;
			ofs2_reg <= `PIC_OFS_DEF;
			flt_reg <= `PIC_FLT_DEF;
		end
		else if (i_ce && i_cfg_write)
		begin
			if (i_config_level)
			begin
				in1_reg <= i_scale_start_input;
				rd1_reg <= i_scale_start_display;
				in2_reg <= i_scale_end_input;
				rd2_reg <= i_scale_end_display;
			end
			sp2_reg <= i_second_probe_enable;
			if (i_sensor_type == `PIC_SENS_TC && i_cold_junction_mode <= `PIC_CJ_50)
				cjm_reg <= i_cold_junction_mode;
			if (i_probe1_offset >= `PIC_OFS_MIN && i_probe1_offset <= `PIC_OFS_MAX)
				ofs1_reg <= i_probe1_offset;
			if (i_probe2_offset >= `PIC_OFS_MIN && i_probe2_offset <= `PIC_OFS_MAX)
				ofs2_reg <= i_probe2_offset;
			flt_reg <= i_input_filter_factor;
		end
	end

	always @*
	begin
		case (cjm_reg)
			`PIC_CJ_0: cj = `PIC_CJV_0;
			`PIC_CJ_25: cj = `PIC_CJV_25;
			`PIC_CJ_40: cj = `PIC_CJV_40;
			`PIC_CJ_50: cj = `PIC_CJV_50;
			default: cj = i_cold_junction_internal;
		endcase
		case (flt_reg)
			3'h0: fac = `PIC_FLT_1;
			3'h1: fac = `PIC_FLT_2;
			3'h2: fac = `PIC_FLT_4;
			3'h3: fac = `PIC_FLT_9;
			3'h4: fac = `PIC_FLT_15;
			3'h5: fac = `PIC_FLT_32;
			3'h6: fac = `PIC_FLT_54;
			default: fac = `PIC_FLT_129;
		endcase
	end

	// ---------------------------------------------------------------
	// Two channels, same sensor type
	// ---------------------------------------------------------------
	pic_ch u_ch1
	(
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_ce(i_ce),
		.i_valid(i_p1_valid),
		.i_raw(i_p1_raw),
		.i_lin(lin),
		.i_sens(i_sensor_type),
		.i_cj(cj),
		.i_in1(in1_reg),
		.i_rd1(rd1_reg),
		.i_in2(in2_reg),
		.i_rd2(rd2_reg),
		.i_ofs(ofs1_reg),
		.i_fac(fac),
		.i_brk_hi(i_break_upper_limit),
		.i_brk_lo(i_break_lower_limit),
		.i_hw_fault(i_p1_hw_fault),
		.o_fault(f1),
		.o_value(v1)
	);

	pic_ch u_ch2
	(
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_ce(i_ce),
		.i_valid(i_p2_valid),
		.i_raw(i_p2_raw),
		.i_lin(lin),
		.i_sens(i_sensor_type),
		.i_cj(cj),
		.i_in1(in1_reg),
		.i_rd1(rd1_reg),
		.i_in2(in2_reg),
		.i_rd2(rd2_reg),
		.i_ofs(ofs2_reg),
		.i_fac(fac),
		.i_brk_hi(i_break_upper_limit),
		.i_brk_lo(i_break_lower_limit),
		.i_hw_fault(i_p2_hw_fault),
		.o_fault(f2_raw),
		.o_value(v2)
	);

	assign f2 = sp2_reg && f2_raw;
	assign any_f = f1 || f2;

	// ---------------------------------------------------------------
	// Program state: faulty-probe mode
	// ---------------------------------------------------------------
	always @*
	begin
		st_next = st_reg;
		case (st_reg)
			`PIC_ST_IDLE:
				if (i_run_req && !any_f)
					st_next = `PIC_ST_RUN;
			`PIC_ST_RUN:
				if (any_f)
					st_next = `PIC_ST_HOLD;
				else if (i_prog_end)
					st_next = `PIC_ST_END;
			`PIC_ST_HOLD:
				if (i_prog_end)
					st_next = `PIC_ST_END;
				else if (!any_f)
					st_next = `PIC_ST_RUN;
			`PIC_ST_END:
				if (i_idle_req)
					st_next = `PIC_ST_IDLE;
			default:
				st_next = `PIC_ST_IDLE;
		endcase
	end

	always @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			st_reg <= `PIC_ST_IDLE;
			prog_reg <= 16'sh0;
		end
		else if (i_ce)
		begin
			st_reg <= st_next;
			// Program follows the lower of active probes (shared setpoint)
			if (sp2_reg && v2 < v1)
				prog_reg <= v2;
			else
				prog_reg <= v1;
		end
	end

	assign o_probe1_value = v1;
	assign o_probe2_value = sp2_reg ? v2 : 16'sh0;
	assign o_prog_value = prog_reg;
	assign o_decimal_point = (i_sensor_type == `PIC_SENS_LIN_DP);
	assign o_cj_visible = (i_sensor_type == `PIC_SENS_TC);
	assign o_sensor_fault_message = any_f;
	assign o_probe1_fault_flag = f1;
	assign o_probe2_fault_flag = f2;
	assign o_holdback_message = (st_reg == `PIC_ST_HOLD);
	assign o_run_refused = (st_reg == `PIC_ST_IDLE) && i_run_req && any_f;
	assign o_out1 = i_ctrl1_out && !f1;
	assign o_out2 = i_ctrl2_out && sp2_reg && !f2;
	assign o_prog_state = st_reg;
endmodule

//--- dv/pic_probe_model.sv
/*
 Behavioural probe front end: one reading strobe at a time.
 Assumes the bench calls send from its main sequence only.
*/
module pic_probe_model
(
	input wire i_clk,
	output logic o_valid,
	output logic signed [15:0] o_raw,
	output logic o_fault
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		o_valid = 1'b0;
		o_raw = 16'sh0;
		o_fault = 1'b0;
	end
	// Between strobes the lines show the inverse of the last reading
	task automatic send(input logic signed [15:0] r, input logic f);
		@(negedge i_clk);
		o_valid = 1'b1;
		o_raw = r;
		o_fault = f;
		@(negedge i_clk);
		o_valid = 1'b0;
		o_raw = ~r;
		o_fault = ~f;
	endtask
endmodule

//--- dv/pic_checker.sv
/*
 Port assertions for pic_top, bound to every instance.
 Assumes one clock with an asynchronous high reset.
*/
module pic_checker
(
	input wire i_clk,
	input wire i_sys_rst,
	input wire i_ce,
	input wire [1:0] i_sensor_type,
	input wire i_p1_valid,
	input wire i_p1_hw_fault,
	input wire i_run_req,
	input wire i_ctrl1_out,
	input wire signed [15:0] o_probe1_value,
	input wire o_decimal_point,
	input wire o_cj_visible,
	input wire o_sensor_fault_message,
	input wire o_probe1_fault_flag,
	input wire o_probe2_fault_flag,
	input wire o_run_refused,
	input wire o_out1,
	input wire o_out2,
	input wire [1:0] o_prog_state
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_sys_rst);
	a_out1_off: assert property (o_probe1_fault_flag |-> !o_out1)
		else $error("out1 on with probe 1 faulty");
	a_out2_off: assert property (o_probe2_fault_flag |-> !o_out2)
		else $error("out2 on with probe 2 faulty");
	a_out1_follows: assert property (!o_probe1_fault_flag |-> o_out1 == i_ctrl1_out)
		else $error("out1 not following its loop");
	a_dp_decode: assert property (o_decimal_point == (i_sensor_type == 2'h3))
		else $error("decimal point wrong");
	a_cj_decode: assert property (o_cj_visible == (i_sensor_type == 2'h0))
		else $error("cold junction visibility wrong");
	a_hold_forced: assert property (i_ce && o_sensor_fault_message && o_prog_state == 2'h1
		|=> o_prog_state == 2'h2) else $error("fault in run without holdback");
	a_run_blocked: assert property (o_prog_state == 2'h0 && o_sensor_fault_message
		&& i_run_req |-> o_run_refused ##1 o_prog_state == 2'h0)
		else $error("run accepted with fault");
	a_value_stands: assert property (!(i_ce && i_p1_valid) |=> $stable(o_probe1_value))
		else $error("value moved without sample");
	a_value_range: assert property (o_probe1_value >= -16'sh7cf
		&& o_probe1_value <= 16'sh270f) else $error("value out of range");
	a_flag_sets: assert property (i_ce && i_p1_valid && i_p1_hw_fault
		|=> o_probe1_fault_flag && o_sensor_fault_message) else $error("fault not flagged");
	a_flag_clears: assert property (i_ce && i_p1_valid && !i_p1_hw_fault
		&& i_sensor_type == 2'h0 |=> !o_probe1_fault_flag) else $error("fault not cleared");
endmodule

bind pic_top pic_checker u_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce),
	.i_sensor_type(i_sensor_type), .i_p1_valid(i_p1_valid), .i_p1_hw_fault(i_p1_hw_fault),
	.i_run_req(i_run_req), .i_ctrl1_out(i_ctrl1_out), .o_probe1_value(o_probe1_value),
	.o_decimal_point(o_decimal_point), .o_cj_visible(o_cj_visible),
	.o_sensor_fault_message(o_sensor_fault_message), .o_probe1_fault_flag(o_probe1_fault_flag),
	.o_probe2_fault_flag(o_probe2_fault_flag), .o_run_refused(o_run_refused),
	.o_out1(o_out1), .o_out2(o_out2), .o_prog_state(o_prog_state));

//--- dv/probe_input_conditioning_bench.sv
/*
 Self-checking bench for pic_top driven through two probe models.
 Assumes the design, the probe model and the checker compile first.
*/
module probe_input_conditioning_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0, rst = 1'b1, wr = 1'b0, lvl = 1'b1, en2 = 1'b0, ce = 1'b1;
	logic run = 1'b0, idl = 1'b0, pend = 1'b0, c1 = 1'b1, c2 = 1'b1;
	logic [1:0] sens = 2'h0;
	logic [2:0] cjm = 3'h0, flt = 3'h2;
	logic signed [15:0] cji = 16'sh0, si = 16'sh0, sd = 16'sh0, ei = 16'sh270f;
	logic signed [15:0] ed = 16'sh270f, of1 = 16'sh0, of2 = 16'sh0;
	logic signed [15:0] bhi = 16'sh270f, blo = -16'sh7cf;
	wire v1v, v2v, h1, h2, dp, cjv, msg, f1, f2, hb, rr, o1, o2;
	wire signed [15:0] r1, r2, pv1, pv2, pv;
	wire [1:0] st;
	int failures = 0, total_checks = 0, cyc = 0;
	int fac[8] = '{1, 2, 4, 9, 15, 32, 54, 129};
	int cjt[5] = '{0, 0, 25, 40, 50};

	pic_top u_dut (.i_clk(clk), .i_sys_rst(rst), .i_ce(ce), .i_sensor_type(sens),
		.i_cold_junction_mode(cjm), .i_cold_junction_internal(cji),
		.i_scale_start_input(si), .i_scale_start_display(sd), .i_scale_end_input(ei),
		.i_scale_end_display(ed), .i_config_level(lvl), .i_cfg_write(wr),
		.i_second_probe_enable(en2), .i_probe1_offset(of1), .i_probe2_offset(of2),
		.i_input_filter_factor(flt), .i_break_upper_limit(bhi), .i_break_lower_limit(blo),
		.i_p1_valid(v1v), .i_p1_raw(r1), .i_p1_hw_fault(h1), .i_p2_valid(v2v),
		.i_p2_raw(r2), .i_p2_hw_fault(h2), .i_run_req(run), .i_idle_req(idl),
		.i_prog_end(pend), .i_ctrl1_out(c1), .i_ctrl2_out(c2), .o_probe1_value(pv1),
		.o_probe2_value(pv2), .o_prog_value(pv), .o_decimal_point(dp), .o_cj_visible(cjv),
		.o_sensor_fault_message(msg), .o_probe1_fault_flag(f1), .o_probe2_fault_flag(f2),
		.o_holdback_message(hb), .o_run_refused(rr), .o_out1(o1), .o_out2(o2),
		.o_prog_state(st));
	pic_probe_model u_m1 (.i_clk(clk), .o_valid(v1v), .o_raw(r1), .o_fault(h1));
	pic_probe_model u_m2 (.i_clk(clk), .o_valid(v2v), .o_raw(r2), .o_fault(h2));

	initial
	begin
		forever #5 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			failures++;
			wrap_up;
		end
	end

	function automatic int sat(int x);
		return x < -1999 ? -1999 : (x > 9999 ? 9999 : x);
	endfunction
	function automatic int scl(int r);
		if (ei == si)
			return sd;
		return sd + (r - si) * (ed - sd) / (ei - si);
	endfunction
	task automatic chk(input logic [15:0] g, input logic [15:0] x);
		total_checks++;
		if (g !== x)
		begin
			failures++;
			$display("[ERR] %0t got %h exp %h", $time, g, x);
		end
	endtask
	task automatic chb(input logic g, input logic x);
		chk({15'h0, g}, {15'h0, x});
	endtask
	task automatic pulse(ref logic s);
		@(negedge clk);
		s = 1'b1;
		@(negedge clk);
		s = 1'b0;
	endtask
	task automatic tc(input int m, input int o, input int r, input int e);
		cjm = 3'(m);
		of1 = 16'(o);
		pulse(wr);
		u_m1.send(16'(r), 1'b0);
		chk(pv1, 16'(e));
	endtask
	task automatic lin;
		int x;
		repeat (3)
		begin
			x = $urandom_range(9999);
			u_m1.send(16'(x), 1'b0);
			chk(pv1, 16'(sat(scl(x))));
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial
	begin
		int k, f, x, a;
		x = $urandom(32'hd2cb);
		repeat (3) @(negedge clk);
		rst = 1'b0;
		chb(o2, 1'b0);
		for (k = 0; k < 4; k++)
		begin
			@(negedge clk);
			sens = 2'(k);
			#1;
			chb(dp, k == 3);
		end
		sens = 2'h0;
		for (k = 0; k <= 8; k++)
		begin
			rst = 1'b1;
			repeat (3) @(negedge clk);
			rst = 1'b0;
			f = k == 8 ? 4 : fac[k];
			flt = 3'(k);
			if (k < 8)
				pulse(wr);
			u_m1.send(16'sh0, 1'b0);
			a = 0;
			repeat (3)
			begin
				x = $urandom_range(200);
				u_m1.send(16'(x), 1'b0);
				a = a + x - a / f;
				chk(pv1, 16'(a / f));
			end
		end
		flt = 3'h0;
		for (k = 0; k < 5; k++)
		begin
			cji = 16'($urandom_range(50));
			f = int'($urandom_range(10998)) - 999;
			x = $urandom_range(3000);
			tc(k, f, x, sat(x + f + (k == 0 ? cji : cjt[k])));
		end
		cji = 16'sh0;
		tc(0, 9999, 9000, 9999);
		tc(0, -999, -1500, -1999);
		tc(5, 10000, 500, -499);
		sens = 2'h2;
		of1 = 16'sh0;
		{si, sd, ei, ed} = {16'sh0, 16'sh0, 16'sh270f, 16'sh64};
		pulse(wr);
		lin;
		u_m1.send(16'sh3000, 1'b0);
		chk(pv1, 16'(sat(scl(9999))));
		u_m1.send(-16'sh5, 1'b0);
		chk(pv1, 16'(sat(scl(0))));
		{si, sd, ei, ed} = {16'sh7d0, 16'sh12c, 16'sh270f, 16'sh7d0};
		pulse(wr);
		lin;
		lvl = 1'b0;
		ed = 16'sh1388;
		pulse(wr);
		ed = 16'sh7d0;
		lvl = 1'b1;
		lin;
		{bhi, blo} = {16'sh5dc, 16'sh190};
		pulse(wr);
		u_m1.send(16'sh1388, 1'b0);
		pulse(run);
		chk({14'h0, st}, 16'h1);
		u_m1.send(16'sh270f, 1'b0);
		chb(f1 & msg & !o1, 1'b1);
		chk(pv1, 16'(sat(scl(5000))));
		@(negedge clk);
		chb(hb, 1'b1);
		u_m1.send(16'sh1388, 1'b0);
		chb(f1 | !o1, 1'b0);
		@(negedge clk);
		chk({14'h0, st}, 16'h1);
		u_m1.send(16'sh0, 1'b0);
		@(negedge clk);
		pulse(pend);
		pulse(idl);
		chk({13'h0, st, msg}, 16'h1);
		@(negedge clk);
		run = 1'b1;
		#1;
		chb(rr, 1'b1);
		@(negedge clk);
		run = 1'b0;
		chk({14'h0, st}, 16'h0);
		u_m1.send(16'sh1388, 1'b0);
		chb(msg, 1'b0);
		{sens, en2} = {2'h0, 1'b1};
		of2 = 16'(int'($urandom_range(1998)) - 999);
		pulse(wr);
		x = $urandom_range(3000);
		k = $urandom_range(3000);
		fork
			u_m1.send(16'(x), 1'b0);
			u_m2.send(16'(k), 1'b0);
		join
		@(negedge clk);
		chk(pv2, 16'(sat(k + of2)));
		chk(pv, 16'(x < sat(k + of2) ? x : sat(k + of2)));
		fork
			u_m1.send(16'h0, 1'b1);
			u_m2.send(16'h0, 1'b1);
		join
		chk({12'h0, f1, f2, o1, o2}, 16'hc);
		en2 = 1'b0;
		pulse(wr);
		@(negedge clk);
		chb(f2, 1'b0);
		chk(pv2, 16'h0);
		ce = 1'b0;
		u_m1.send(16'sh64, 1'b0);
		chb(f1, 1'b1);
		chk(pv1, 16'(x));
		ce = 1'b1;
		wrap_up;
	end
endmodule
